// *** rtl/accel_host_ctrl.sv ***
// host controller: APB slave that drives the accelerometer register port
module accel_host_ctrl
	import accel_regs_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        rstn_i,
	input  wire logic        en_i,
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [11:0] paddr_i,
	input  wire logic [31:0] pwdata_i,
	output logic [31:0]      prdata_o,
	output logic             pready_o,
	output logic             pslverr_o,
	accel_reg_if.host        dev
);
	logic       req_q;
	logic       we_q;
	logic [7:0] addr_q;
	logic [7:0] wdata_q;
	logic [7:0] rdata_q;
	logic       init_done_q;
	logic       nv_busy_q;
	logic       apb_wr;
	logic       cmd_ok;

	assign apb_wr = psel_i & penable_i & pwrite_i;
	// a command while one is outstanding is dropped: poll busy first
	assign cmd_ok = apb_wr & (paddr_i == APB_CMD) & pwdata_i[CMD_GO]
		& ~req_q;

	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			req_q <= 1'b0;
			we_q <= 1'b0;
			addr_q <= ZERO_BYTE;
			wdata_q <= ZERO_BYTE;
		end else if (en_i) begin
			if (cmd_ok) begin
				req_q <= 1'b1;
				we_q <= pwdata_i[CMD_WRITE];
				addr_q <= pwdata_i[15:8];
				wdata_q <= (pwdata_i[15:8] == ADDR_Z_DRIVE)
					? (pwdata_i[7:0] & Z_DRIVE_MASK)
					: (pwdata_i[15:8] == ADDR_INIT_TWO)
					? ZERO_BYTE
					: pwdata_i[7:0];
			end else if (!init_done_q && !req_q) begin
				req_q <= 1'b1;
				we_q <= 1'b1;
				addr_q <= ADDR_INIT_TWO;
				wdata_q <= ZERO_BYTE;
			end else if (dev.ack) begin
				req_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			init_done_q <= 1'b0;
			rdata_q <= ZERO_BYTE;
			nv_busy_q <= 1'b0;
		end else if (en_i && req_q && dev.ack) begin
			if (addr_q == ADDR_INIT_TWO && we_q) begin
				init_done_q <= 1'b1;
			end
			if (!we_q) begin
				rdata_q <= dev.rdata;
			end
			if (!we_q && addr_q == ADDR_STATUS_1) begin
				nv_busy_q <= dev.rdata[BIT_NV_BUSY];
			end
		end
	end

	// read data is latched in the setup cycle so it stands for the access
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			prdata_o <= 32'h0000_0000;
		end else if (en_i && psel_i && !penable_i) begin
			case (paddr_i)
				APB_STATUS: prdata_o <= {29'h0, nv_busy_q,
					init_done_q, req_q};
				APB_RDATA:  prdata_o <= {24'h00_0000, rdata_q};
				default:    prdata_o <= 32'h0000_0000;
			endcase
		end
	end

	assign pready_o = 1'b1;
	assign pslverr_o = psel_i & penable_i & (paddr_i != APB_CMD)
		& (paddr_i != APB_STATUS) & (paddr_i != APB_RDATA);
	assign dev.req = req_q;
	assign dev.we = we_q;
	assign dev.addr = addr_q;
	assign dev.wdata = wdata_q;
endmodule : accel_host_ctrl

// *** rtl/accel_reg_if.sv ***
// register port between the accelerometer bank and its host
interface accel_reg_if;
	logic       req;
	logic       we;
	logic [7:0] addr;
	logic [7:0] wdata;
	logic [7:0] rdata;
	logic       ack;
	logic       three_wire;
	modport device (input req, we, addr, wdata, output rdata, ack,
		three_wire);
	modport host (output req, we, addr, wdata, input rdata, ack,
		three_wire);
endinterface : accel_reg_if

// *** rtl/accel_regs_pkg.sv ***
// constants shared by the accelerometer register bank and its host controller
package accel_regs_pkg;
	localparam logic [7:0] ADDR_STATUS_1      = 8'h01;
	localparam logic [7:0] ADDR_MODE_CTRL     = 8'h10;
	localparam logic [7:0] ADDR_RATE_1        = 8'h11;
	localparam logic [7:0] ADDR_Z_DRIVE       = 8'h22;
	localparam logic [7:0] ADDR_SOFT_RESET    = 8'h24;
	localparam logic [7:0] ADDR_INIT_TWO      = 8'h28;
	localparam logic [7:0] ADDR_SAMPLE_COUNT  = 8'h29;
	localparam logic [7:0] ADDR_X_OFF_LOW     = 8'h2a;
	localparam logic [7:0] ADDR_X_OFF_HIGH    = 8'h2b;
	localparam logic [7:0] ADDR_Y_OFF_LOW     = 8'h2c;
	localparam logic [7:0] ADDR_Y_OFF_HIGH    = 8'h2d;
	localparam int         BIT_Z_PLUS         = 2;
	localparam int         BIT_Z_MINUS        = 3;
	localparam logic [7:0] Z_DRIVE_MASK       = 8'h0c;
	localparam int         BIT_POR            = 6;
	localparam int         BIT_RELOAD         = 7;
	localparam logic [7:0] SOFT_RESET_MASK    = 8'hc0;
	localparam int         BIT_NV_BUSY        = 5;
	localparam logic [2:0] MODE_MASK_HI       = 3'h7;
	localparam logic [7:0] MODE_FIELD_MASK    = 8'h07;
	localparam logic [7:0] RATE_SDR_MASK      = 8'h70;
	localparam logic [7:0] RATE_SDR_CODE      = 8'h70;
	localparam logic [7:0] COUNT_CONTINUOUS   = 8'hff;
	localparam logic [7:0] ZERO_BYTE          = 8'h00;
	localparam logic [14:0] X_OFFSET_FACTORY  = 15'h0000;
	localparam logic [14:0] Y_OFFSET_FACTORY  = 15'h0000;
	localparam logic [8:0]  X_GAIN_FACTORY    = 9'h100;
	localparam logic [8:0]  Y_GAIN_FACTORY    = 9'h100;
	localparam logic [7:0] NV_LOAD_CYCLES     = 8'h10;
	// host controller APB map
	localparam logic [11:0] APB_CMD           = 12'h000;
	localparam logic [11:0] APB_STATUS        = 12'h004;
	localparam logic [11:0] APB_RDATA         = 12'h008;
	localparam int          CMD_GO            = 31;
	localparam int          CMD_WRITE         = 30;
	localparam int          STAT_BUSY         = 0;
	localparam int          STAT_INIT_DONE    = 1;
	localparam int          STAT_NV_BUSY      = 2;
	typedef enum logic [1:0] {
		SEQ_IDLE,
		SEQ_POR,
		SEQ_RELOAD
	} nv_seq_t;
endpackage : accel_regs_pkg

// *** rtl/accel_reset_trigger_offset_regs.sv ***
// accelerometer reset, trigger count, self-test and offset registers
module accel_reset_trigger_offset_regs
	import accel_regs_pkg::*;
(
	input  wire logic               clk_i,
	input  wire logic               rstn_i,
	input  wire logic               en_i,
	accel_reg_if.device             bus,
	input  wire logic               sample_tick_i,
	input  wire logic               trigger_start_i,
	input  wire logic signed [15:0] x_raw_i,
	input  wire logic signed [15:0] y_raw_i,
	output logic signed [15:0]      x_ext_o,
	output logic signed [15:0]      y_ext_o,
	output logic                    z_plus_drive_o,
	output logic                    z_minus_drive_o,
	output logic                    sampling_o,
	output logic                    nv_busy_o,
	output logic [8:0]              x_gain_value_o,
	output logic [8:0]              y_gain_value_o
);
	logic [7:0]  z_drive_motion_q;
	logic [7:0]  init_fixed_two_q;
	logic [7:0]  oneshot_sample_count_q;
	logic [7:0]  soft_defined_rate_q;
	logic [7:0]  mode_ctrl_q;
	logic [7:0]  rate_one_q;
	logic        reload_q;
	logic        three_wire_q;
	logic [14:0] x_offset_value_q;
	logic [14:0] y_offset_value_q;
	logic [8:0]  x_gain_value_q;
	logic [8:0]  y_gain_value_q;
	nv_seq_t     seq_q;
	logic [7:0]  seq_cnt_q;
	logic [7:0]  left_q;
	logic        run_q;
	logic [7:0]  rdata_q;
	logic        ack_q;
	logic        wr;
	logic        sdr_sel;
	logic        por_req;
	logic        load_done;
	logic        soft_clear;

	assign wr = bus.req & bus.we;
	assign sdr_sel = (rate_one_q & RATE_SDR_MASK) == RATE_SDR_CODE;
	assign por_req = wr & (bus.addr == ADDR_SOFT_RESET)
		& bus.wdata[BIT_POR];
	assign load_done = (seq_q != SEQ_IDLE) & (seq_cnt_q == ZERO_BYTE);
	// por sequence wipes the control registers, reload bit and run state; offsets and gains it reloads
	assign soft_clear = load_done & (seq_q == SEQ_POR);

	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			seq_q <= SEQ_IDLE;
			seq_cnt_q <= ZERO_BYTE;
		end else if (en_i) begin
			if (por_req) begin
				seq_q <= SEQ_POR;
				seq_cnt_q <= NV_LOAD_CYCLES;
			end else if (wr & (bus.addr == ADDR_SOFT_RESET)
				& bus.wdata[BIT_RELOAD] & ~reload_q) begin
				seq_q <= SEQ_RELOAD;
				seq_cnt_q <= NV_LOAD_CYCLES;
			end else if (load_done) begin
				seq_q <= SEQ_IDLE;
			end else if (seq_q != SEQ_IDLE) begin
				seq_cnt_q <= seq_cnt_q - 8'h01;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			reload_q <= 1'b0;
		end else if (en_i) begin
			if (soft_clear) begin
				reload_q <= 1'b0;
			end else if (wr & (bus.addr == ADDR_SOFT_RESET)) begin
				reload_q <= bus.wdata[BIT_RELOAD];
			end
		end
	end

	// the soft clear waits for the enable so a frozen bank stays frozen
	always_ff @(posedge clk_i) begin
		if (!rstn_i || (en_i && soft_clear)) begin
			z_drive_motion_q <= ZERO_BYTE;
			init_fixed_two_q <= ZERO_BYTE;
			oneshot_sample_count_q <= ZERO_BYTE;
			soft_defined_rate_q <= ZERO_BYTE;
			mode_ctrl_q <= ZERO_BYTE;
			rate_one_q <= ZERO_BYTE;
			three_wire_q <= 1'b0;
		end else if (en_i && wr) begin
			case (bus.addr)
				ADDR_Z_DRIVE:
					z_drive_motion_q <= bus.wdata & Z_DRIVE_MASK;
				ADDR_INIT_TWO:
					init_fixed_two_q <= bus.wdata;
				ADDR_SAMPLE_COUNT: begin
					if (sdr_sel) begin
						soft_defined_rate_q <= bus.wdata;
					end else begin
						oneshot_sample_count_q <= bus.wdata;
					end
				end
				ADDR_MODE_CTRL:
					mode_ctrl_q <= bus.wdata & MODE_FIELD_MASK;
				ADDR_RATE_1:
					rate_one_q <= bus.wdata;
				default: begin
					three_wire_q <= three_wire_q;
				end
			endcase
		end
	end

	// offsets and gains go back to factory values at the end of every por or reload sequence
	always_ff @(posedge clk_i) begin
		if (!rstn_i || (en_i && load_done)) begin
			x_offset_value_q <= X_OFFSET_FACTORY;
			y_offset_value_q <= Y_OFFSET_FACTORY;
			x_gain_value_q <= X_GAIN_FACTORY;
			y_gain_value_q <= Y_GAIN_FACTORY;
		end else if (en_i && wr) begin
			case (bus.addr)
				ADDR_X_OFF_LOW:
					x_offset_value_q[7:0] <= bus.wdata;
				ADDR_X_OFF_HIGH: begin
					x_offset_value_q[14:8] <= bus.wdata[6:0];
					x_gain_value_q[8] <= bus.wdata[7];
				end
				ADDR_Y_OFF_LOW:
					y_offset_value_q[7:0] <= bus.wdata;
				ADDR_Y_OFF_HIGH: begin
					y_offset_value_q[14:8] <= bus.wdata[6:0];
					y_gain_value_q[8] <= bus.wdata[7];
				end
				default: begin
					x_gain_value_q <= x_gain_value_q;
				end
			endcase
		end
	end

	// one-shot sampling: a mode write ends continuous runs
	always_ff @(posedge clk_i) begin
		if (!rstn_i || (en_i && soft_clear)) begin
			run_q <= 1'b0;
			left_q <= ZERO_BYTE;
		end else if (en_i) begin
			if (wr && bus.addr == ADDR_MODE_CTRL) begin
				run_q <= 1'b0;
			end else if (trigger_start_i && !sdr_sel
				&& oneshot_sample_count_q != ZERO_BYTE) begin
				run_q <= 1'b1;
				left_q <= oneshot_sample_count_q;
			end else if (run_q && sample_tick_i
				&& left_q != COUNT_CONTINUOUS) begin
				left_q <= left_q - 8'h01;
				if (left_q == 8'h01) begin
					run_q <= 1'b0;
				end
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			x_ext_o <= 16'sh0000;
			y_ext_o <= 16'sh0000;
		end else if (en_i && run_q && sample_tick_i) begin
			x_ext_o <= x_raw_i + 16'(signed'(x_offset_value_q));
			y_ext_o <= y_raw_i + 16'(signed'(y_offset_value_q));
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			rdata_q <= ZERO_BYTE;
			ack_q <= 1'b0;
		end else if (en_i) begin
			ack_q <= bus.req;
			case (bus.addr)
				ADDR_STATUS_1:
					rdata_q <= {2'b00, reload_q & (seq_q != SEQ_IDLE),
						5'b00000};
				ADDR_Z_DRIVE:      rdata_q <= z_drive_motion_q;
				ADDR_SOFT_RESET:
					rdata_q <= {reload_q, 7'b0000000};
				ADDR_INIT_TWO:     rdata_q <= init_fixed_two_q;
				ADDR_SAMPLE_COUNT:
					rdata_q <= sdr_sel ? soft_defined_rate_q
						: oneshot_sample_count_q;
				ADDR_MODE_CTRL:    rdata_q <= mode_ctrl_q;
				ADDR_RATE_1:       rdata_q <= rate_one_q;
				default:           rdata_q <= ZERO_BYTE;
			endcase
		end
	end

	assign bus.rdata = rdata_q;
	assign bus.ack = ack_q;
	assign bus.three_wire = three_wire_q;
	assign z_plus_drive_o = z_drive_motion_q[BIT_Z_PLUS];
	assign z_minus_drive_o = z_drive_motion_q[BIT_Z_MINUS];
	assign sampling_o = run_q;
	assign nv_busy_o = seq_q != SEQ_IDLE;
	assign x_gain_value_o = x_gain_value_q;
	assign y_gain_value_o = y_gain_value_q;
endmodule : accel_reset_trigger_offset_regs

// *** tb/accel_regs_checker.sv ***
// checker on the register port joining host controller and bank
module accel_regs_checker
	import accel_regs_pkg::*;
(
	input  wire logic       clk_i,
	input  wire logic       rstn_i,
	input  wire logic       req,
	input  wire logic       we,
	input  wire logic [7:0] addr,
	input  wire logic [7:0] wdata,
	input  wire logic [7:0] rdata,
	input  wire logic       ack,
	input  wire logic       three_wire
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rstn_i);
	wire rd = req && !we && ack;
	wire wr = req && we;
	AST_FOUR_WIRE: assert property (!three_wire)
		else $error("three-wire mode seen");
	AST_Z_WR: assert property (wr && addr == ADDR_Z_DRIVE |->
		(wdata & ~Z_DRIVE_MASK) == 8'h00) else $error("z drive spare bits");
	AST_INIT_WR: assert property (wr && addr == ADDR_INIT_TWO |->
		wdata == ZERO_BYTE) else $error("init value not zero");
	AST_INIT_SOON: assert property ($rose(rstn_i) |->
		##[0:30] wr && addr == ADDR_INIT_TWO) else $error("no init write");
	AST_Z_RD: assert property (rd && addr == ADDR_Z_DRIVE |->
		(rdata & ~Z_DRIVE_MASK) == 8'h00) else $error("z drive readback");
	AST_POR_RD: assert property (rd && addr == ADDR_SOFT_RESET |->
		!rdata[BIT_POR]) else $error("power-on bit stuck");
	AST_RESV_RD: assert property (rd && addr == ADDR_SOFT_RESET |->
		rdata[5:0] == 6'h00) else $error("reserved bits read");
	AST_OFF_RD: assert property (rd && addr >= ADDR_X_OFF_LOW &&
		addr <= ADDR_Y_OFF_HIGH |-> rdata == 8'h00) else $error("offset read");
	cover property (wr && addr == ADDR_SOFT_RESET && wdata[BIT_POR]);
	cover property (wr && addr == ADDR_SOFT_RESET && wdata[BIT_RELOAD]);
	cover property (rd && addr == ADDR_X_OFF_HIGH);
endmodule : accel_regs_checker

// *** tb/tb.sv ***
// self-checking bench: host controller and register bank back to back
module tb;
	import accel_regs_pkg::*;
	timeunit 1ns;
	timeprecision 100ps;
	logic               clk_i = 0, rstn_i = 0, tick = 0, trig = 0;
	logic               psel = 0, penable = 0, pwrite = 0, want = 0;
	logic [11:0]        paddr = '0;
	logic [31:0]        pwdata = '0, prdata, rd_v;
	logic               pready, pslverr, err, zp, zm, smp, nvb;
	logic signed [15:0] xr = '0, yr = '0, xe, ye;
	logic [15:0]        ox, oy;
	logic [8:0]         xg, yg;
	logic [31:0]        exp_q[$];
	logic [7:0]         rst_addr[6] = '{ADDR_Z_DRIVE, ADDR_SOFT_RESET,
		ADDR_INIT_TWO, ADDR_SAMPLE_COUNT, ADDR_X_OFF_LOW, ADDR_Y_OFF_HIGH};
	int                 fails = 0, tests_run = 0, seed = 32'hd3e0;
	accel_reg_if bus_if();
	accel_host_ctrl accel_host_ctrl_inst(.clk_i(clk_i), .rstn_i(rstn_i),
		.en_i(1'b1), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
		.paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
		.pready_o(pready), .pslverr_o(pslverr), .dev(bus_if));
	accel_reset_trigger_offset_regs accel_reset_trigger_offset_regs_inst(
		.clk_i(clk_i), .rstn_i(rstn_i), .en_i(1'b1), .bus(bus_if),
		.sample_tick_i(tick), .trigger_start_i(trig), .x_raw_i(xr),
		.y_raw_i(yr), .x_ext_o(xe), .y_ext_o(ye), .z_plus_drive_o(zp),
		.z_minus_drive_o(zm), .sampling_o(smp), .nv_busy_o(nvb),
		.x_gain_value_o(xg), .y_gain_value_o(yg));
	accel_regs_checker accel_regs_checker_inst(.clk_i(clk_i),
		.rstn_i(rstn_i), .req(bus_if.req), .we(bus_if.we),
		.addr(bus_if.addr), .wdata(bus_if.wdata), .rdata(bus_if.rdata),
		.ack(bus_if.ack), .three_wire(bus_if.three_wire));
	always #2.5 clk_i = ~clk_i;
	task automatic report_and_stop();
		$display("fails %0d tests_run %0d", fails, tests_run);
		if (fails == 0 && tests_run > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : report_and_stop
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			fails++;
			$display("Error at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic bound(input int n);
		if (n >= 200) begin
			fails++;
			report_and_stop();
		end
	endtask : bound
	// expected read values reach the monitor below through exp_q
	task automatic apb(input logic [11:0] a, input logic w,
		input logic [31:0] d, input logic chk);
		int n;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		want <= chk;
		@(posedge clk_i);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (pready !== 1'b1 && n < 200);
		bound(n);
		rd_v = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		want <= 1'b0;
		// one idle edge so the next call never re-drives psel in this step
		@(posedge clk_i);
	endtask : apb
	always @(posedge clk_i)
		if (psel && penable && pready && !pwrite && want && exp_q.size() > 0)
			check(prdata, exp_q.pop_front());
	// busy is polled rather than timed, so host latency may change freely
	task automatic cmd(input logic w, input logic [7:0] a, input logic [7:0] d);
		int n;
		apb(APB_CMD, 1'b1, {1'b1, w, 14'h0, a, d}, 1'b0);
		n = 0;
		do begin
			apb(APB_STATUS, 1'b0, 32'h0, 1'b0);
			n++;
		end while (rd_v[STAT_BUSY] !== 1'b0 && n < 200);
		bound(n);
	endtask : cmd
	task automatic dev_read(input logic [7:0] a, input logic [7:0] e);
		cmd(1'b0, a, 8'h00);
		exp_q.push_back({24'h0, e});
		apb(APB_RDATA, 1'b0, 32'h0, 1'b1);
	endtask : dev_read
	task automatic ticks(input int n);
		repeat (n) begin
			tick <= 1'b1;
			@(posedge clk_i);
			tick <= 1'b0;
			repeat (3) @(posedge clk_i);
		end
	endtask : ticks
	task automatic start_and_count(input logic [7:0] c);
		cmd(1'b1, ADDR_SAMPLE_COUNT, c);
		trig <= 1'b1;
		@(posedge clk_i);
		trig <= 1'b0;
		repeat (2) @(posedge clk_i);
	endtask : start_and_count
	task automatic wait_nv();
		int n;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (nvb !== 1'b0 && n < 200);
		bound(n);
	endtask : wait_nv
	// the host's own init write must land before any command is taken
	task automatic wait_init();
		int n;
		n = 0;
		do begin
			apb(APB_STATUS, 1'b0, 32'h0, 1'b0);
			n++;
		end while (rd_v[STAT_INIT_DONE] !== 1'b1 && n < 200);
		bound(n);
	endtask : wait_init
	initial begin
		repeat (10) @(posedge clk_i);
		rstn_i <= 1'b1;
		wait_init();
		check(rd_v[STAT_INIT_DONE], 32'h1);
		check(rd_v[STAT_BUSY], 32'h0);
		foreach (rst_addr[i])
			dev_read(rst_addr[i], ZERO_BYTE);
		dev_read(ADDR_Y_OFF_HIGH, 8'h00);
		for (int i = 0; i < 4; i++) begin
			cmd(1'b1, ADDR_Z_DRIVE, {4'hf, 2'(i), 2'h3});
			check(zp, 32'(i % 2));
			check(zm, 32'(i / 2));
			dev_read(ADDR_Z_DRIVE, 8'(i << 2));
		end
		xr <= 16'($random(seed));
		yr <= 16'($random(seed));
		ox = 16'($random(seed));
		oy = 16'($random(seed));
		cmd(1'b1, ADDR_X_OFF_LOW, ox[7:0]);
		cmd(1'b1, ADDR_X_OFF_HIGH, ox[15:8]);
		cmd(1'b1, ADDR_Y_OFF_LOW, oy[7:0]);
		cmd(1'b1, ADDR_Y_OFF_HIGH, oy[15:8]);
		start_and_count(8'h01);
		ticks(1);
		check(smp, 32'h0);
		check({xe}, 16'(xr + {ox[14], ox[14:0]}));
		check({ye}, 16'(yr + {oy[14], oy[14:0]}));
		check(xg, {ox[15], X_GAIN_FACTORY[7:0]});
		check(yg, {oy[15], Y_GAIN_FACTORY[7:0]});
		dev_read(ADDR_X_OFF_LOW, 8'h00);
		start_and_count(8'h03);
		ticks(2);
		check(smp, 32'h1);
		ticks(1);
		check(smp, 32'h0);
		start_and_count(COUNT_CONTINUOUS);
		ticks(260);
		check(smp, 32'h1);
		cmd(1'b1, ADDR_MODE_CTRL, 8'h00);
		check(smp, 32'h0);
		cmd(1'b1, ADDR_RATE_1, RATE_SDR_CODE);
		cmd(1'b1, ADDR_SAMPLE_COUNT, 8'h5a);
		dev_read(ADDR_SAMPLE_COUNT, 8'h5a);
		cmd(1'b1, ADDR_RATE_1, ZERO_BYTE);
		dev_read(ADDR_SAMPLE_COUNT, COUNT_CONTINUOUS);
		cmd(1'b1, ADDR_SOFT_RESET, 8'h7f);
		wait_nv();
		dev_read(ADDR_SOFT_RESET, 8'h00);
		dev_read(ADDR_Z_DRIVE, 8'h00);
		check(zp, 32'h0);
		check(xg, X_GAIN_FACTORY);
		cmd(1'b1, ADDR_SOFT_RESET, 8'h80);
		dev_read(ADDR_STATUS_1, 8'(1 << BIT_NV_BUSY));
		apb(APB_STATUS, 1'b0, 32'h0, 1'b0);
		check(rd_v[STAT_NV_BUSY], 32'h1);
		wait_nv();
		dev_read(ADDR_SOFT_RESET, 8'h80);
		cmd(1'b1, ADDR_SOFT_RESET, 8'h00);
		dev_read(ADDR_SOFT_RESET, 8'h00);
		apb(12'h00c, 1'b0, 32'h0, 1'b0);
		check(err, 32'h1);
		check(rd_v, 32'h0);
		report_and_stop();
	end
endmodule : tb
